// ---- hdl/nbhc_pkg.sv ----
/*
 * Shared constants of the NAND bus host controller: request kinds,
 * command codes, address lane masks, strobe timing and status bit
 * positions.
 * Assumes a 100 MHz system clock.
 */
package nbhc_pkg;

   typedef enum logic [2:0] {
      NBHC_KIND_CMD,
      NBHC_KIND_ADDR,
      NBHC_KIND_DIN,
      NBHC_KIND_DOUT,
      NBHC_KIND_WAIT
   } nbhc_kind_type;

   typedef enum logic [1:0] {
      NBHC_RD_ARRAY,
      NBHC_RD_STATUS,
      NBHC_RD_EDC
   } nbhc_rdmode_type;

   localparam int unsigned IO_WIDTH = 16;
   localparam int unsigned CODE_WIDTH = 8;

   // Command codes
   localparam logic [7:0] CMD_READ_SETUP = 8'h00;
   localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
   localparam logic [7:0] CMD_READ_COPYBACK = 8'h35;
   localparam logic [7:0] CMD_CACHE_READ = 8'h31;
   localparam logic [7:0] CMD_CACHE_END = 8'h3f;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
   localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_RAND_OUT = 8'h05;
   localparam logic [7:0] CMD_RAND_OUT_CONFIRM = 8'he0;
   localparam logic [7:0] CMD_RAND_IN = 8'h85;
   localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
   localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
   localparam logic [7:0] CMD_PLANE_DUMMY = 8'h11;
   localparam logic [7:0] CMD_PLANE_SECOND = 8'h81;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_EDC_STATUS = 8'h7b;
   localparam logic [7:0] CMD_RESET = 8'hff;

   // Address cycles and reserved lanes
   localparam logic [2:0] ADDR_CYCLES = 3'h5;
   localparam logic [2:0] ADDR_IDX_COL_HI = 3'h1;
   localparam logic [2:0] ADDR_IDX_LAST = 3'h4;
   localparam logic [7:0] ADDR_MASK_FULL = 8'hff;
   localparam logic [7:0] ADDR_MASK_COL_HI_X8 = 8'h0f;
   localparam logic [7:0] ADDR_MASK_COL_HI_X16 = 8'h07;
   localparam logic [7:0] ADDR_MASK_LAST = 8'h03;

   // Status bit positions
   localparam int unsigned STAT_BIT_READY = 6;
   localparam int unsigned STAT_BIT_FAIL = 0;

   // Strobe timing
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned SETUP_NS = 20;
   localparam int unsigned WE_LOW_NS = 20;
   localparam int unsigned RE_LOW_NS = 40;
   localparam int unsigned HOLD_NS = 20;
   localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] WE_LOW_CYC = 4'((WE_LOW_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] RE_LOW_CYC = 4'((RE_LOW_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS * CLK_MHZ + 999) / 1000);

   // Reset values of pin drivers
   localparam logic RST_CE_N = 1'b1;
   localparam logic RST_WE_N = 1'b1;
   localparam logic RST_RE_N = 1'b1;
   localparam logic RST_WP_N = 1'b0;

endpackage : nbhc_pkg

// ---- hdl/nbhc_buf2.sv ----
/*
 * Two-entry buffer with valid/ready on both sides; head entry is a
 * register so the drain side sees flop outputs.
 * Assumes both sides on the same clock.
 */
`timescale 1ns/100ps
module nbhc_buf2 #(
   parameter int unsigned WIDTH = 16
) (
   input wire logic clk_in,               // System clock
   input wire logic rst_in,               // Async reset, high
   input wire logic en_in,                // Clock enable
   input wire logic in_valid_in,          // Fill side valid
   output logic in_ready_out,             // Fill side ready
   input wire logic [WIDTH-1:0] in_data_in, // Fill side data
   output logic out_valid_out,            // Drain side valid
   input wire logic out_ready_in,         // Drain side ready
   output logic [WIDTH-1:0] out_data_out  // Drain side data
);
   logic [WIDTH-1:0] slot_reg [0:1];
   logic [1:0] full_reg;
   logic push;
   logic pop;

   assign in_ready_out = !full_reg[1];
   assign out_valid_out = full_reg[0];
   assign out_data_out = slot_reg[0];
   assign push = in_valid_in && !full_reg[1];
   assign pop = full_reg[0] && out_ready_in;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         full_reg <= 2'h0;
      end else if (en_in) begin
         if (pop) begin
            full_reg[0] <= full_reg[1] || push;
            full_reg[1] <= 1'b0;
         end else if (push) begin
            full_reg[full_reg[0]] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (en_in) begin
         if (pop) begin
            slot_reg[0] <= full_reg[1] ? slot_reg[1] : in_data_in;
         end else if (push) begin
            slot_reg[full_reg[0]] <= in_data_in;
         end
      end
   end

endmodule : nbhc_buf2

// ---- hdl/nbhc_host.sv ----
/*
 * NAND bus host controller: turns user requests (command, address,
 * data in, data out, wait for ready) into strobed pin cycles.
 * Assumes the ready/busy line is pulled up on the board and the
 * data lanes are resolved from the output enable by the surroundings.
 */
// Behaviour
// - Lanes held stable around each write strobe rising edge.
// - Chip select low chooses the device; deselected cycles are ignored.
// - Byte-wide address: five cycles, reserved lanes low.
// - Word-wide address: five cycles, reserved lanes low.
// - Read, erase, identifier, random output/input, cache end codes.
// - Two-plane program sequences 80h/85h, 11h, 81h, 10h.
// - Command codes always on the low eight lanes.
`timescale 1ns/100ps
module nbhc_host (
   input wire logic SYS_CLK_IN,                    // 100 MHz clock
   input wire logic SYS_RST_IN,                    // Async reset, high
   input wire logic CLK_EN_IN,                     // Freezes all state low
   input wire logic WIDE_BUS_IN,                   // Word-wide device
   input wire logic WRITE_ALLOW_IN,                // Permit modify ops
   input wire logic REQ_VALID_IN,                  // Request present
   input wire nbhc_pkg::nbhc_kind_type REQ_KIND_IN, // Request kind
   input wire logic [15:0] REQ_DATA_IN,            // Code, address or data
   output logic REQ_READY_OUT,                     // Controller idle
   output logic REQ_ACK_OUT,                       // Request taken pulse
   output logic [15:0] RD_DATA_OUT,                // Read word
   output logic RD_VALID_OUT,                      // Read word valid
   input wire logic RD_READY_IN,                   // Read word taken
   output logic STAT_READY_OUT,                    // Last status: done
   output logic STAT_FAIL_OUT,                     // Last status: failed
   output logic BUSY_OUT,                          // Device busy seen
   output logic NAND_CE_N_OUT,                     // Chip select
   output logic NAND_CLE_OUT,                      // Command latch
   output logic NAND_ALE_OUT,                      // Address latch
   output logic NAND_WE_N_OUT,                     // Write strobe
   output logic NAND_RE_N_OUT,                     // read_strobe_n pin
   output logic NAND_WP_N_OUT,                     // Write protect
   output logic [15:0] NAND_IO_OUT,                // Lane drive value
   output logic NAND_IO_OE_OUT,                    // Lane drive enable
   input wire logic [15:0] NAND_IO_IN,             // Lane level
   input wire logic NAND_RB_IN                     // Ready/busy level
);
   import nbhc_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE, ST_SETUP, ST_LOW, ST_HOLD
   } nbhc_state_type;

   nbhc_state_type state_reg;
   nbhc_kind_type kind_reg;
   nbhc_rdmode_type rdmode_reg;
   logic [3:0] cnt_reg;
   logic [2:0] addr_idx_reg;
   logic [15:0] io_meta_reg;
   logic [15:0] io_sync_reg;
   logic [1:0] rb_sync_reg;
   logic ack_reg;
   logic accept;
   logic allowed;
   logic push;
   logic buf_ready;
   logic [15:0] drive_val;

   function automatic logic [7:0] addr_mask(input logic [2:0] idx,
                                            input logic wide);
      if (idx == ADDR_IDX_COL_HI) begin
         addr_mask = wide ? ADDR_MASK_COL_HI_X16 : ADDR_MASK_COL_HI_X8;
      end else if (idx == ADDR_IDX_LAST) begin
         addr_mask = ADDR_MASK_LAST;
      end else begin
         addr_mask = ADDR_MASK_FULL;
      end
   endfunction : addr_mask

   function automatic logic busy_ok(input nbhc_kind_type kind,
                                    input logic [7:0] code);
      busy_ok = (kind == NBHC_KIND_DOUT) || (kind == NBHC_KIND_WAIT) ||
         ((kind == NBHC_KIND_CMD) &&
          (code == CMD_RESET || code == CMD_STATUS));
   endfunction : busy_ok

   // Pin synchronisers
   always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         io_meta_reg <= 16'h0000;
         io_sync_reg <= 16'h0000;
         rb_sync_reg <= 2'h0;
      end else if (CLK_EN_IN) begin
         io_meta_reg <= NAND_IO_IN;
         io_sync_reg <= io_meta_reg;
         rb_sync_reg <= {rb_sync_reg[0], NAND_RB_IN};
      end
   end

   assign BUSY_OUT = !rb_sync_reg[1];
   assign allowed = !BUSY_OUT || busy_ok(REQ_KIND_IN, REQ_DATA_IN[7:0]);
   assign accept = REQ_VALID_IN && REQ_READY_OUT && allowed &&
      (REQ_KIND_IN != NBHC_KIND_DOUT || buf_ready);

   // Upper lanes forced low on command and address cycles
   always_comb begin
      drive_val = REQ_DATA_IN;
      if (REQ_KIND_IN == NBHC_KIND_CMD) begin
         drive_val = {8'h00, REQ_DATA_IN[7:0]};
      end else if (REQ_KIND_IN == NBHC_KIND_ADDR) begin
         drive_val = {8'h00, REQ_DATA_IN[7:0] &
            addr_mask(addr_idx_reg, WIDE_BUS_IN)};
      end
   end

   // Sequencer
   always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         state_reg <= ST_IDLE;
         kind_reg <= NBHC_KIND_CMD;
         cnt_reg <= 4'h0;
         REQ_READY_OUT <= 1'b0;
      end else if (CLK_EN_IN) begin
         unique case (state_reg)
            ST_IDLE: begin
               REQ_READY_OUT <= !accept;
               if (accept) begin
                  kind_reg <= REQ_KIND_IN;
                  cnt_reg <= SETUP_CYC;
                  state_reg <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (kind_reg == NBHC_KIND_WAIT) begin
                  if (!BUSY_OUT) begin
                     state_reg <= ST_IDLE;
                     REQ_READY_OUT <= 1'b1;
                  end
               end else if (cnt_reg <= 4'h1) begin
                  cnt_reg <= (kind_reg == NBHC_KIND_DOUT) ?
                     RE_LOW_CYC : WE_LOW_CYC;
                  state_reg <= ST_LOW;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            ST_LOW: begin
               if (cnt_reg <= 4'h1) begin
                  cnt_reg <= HOLD_CYC;
                  state_reg <= ST_HOLD;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            ST_HOLD: begin
               if (cnt_reg <= 4'h1) begin
                  state_reg <= ST_IDLE;
                  REQ_READY_OUT <= 1'b1;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
         endcase
      end
   end

   // Pin drivers
   always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         NAND_CE_N_OUT <= RST_CE_N;
         NAND_CLE_OUT <= 1'b0;
         NAND_ALE_OUT <= 1'b0;
         NAND_WE_N_OUT <= RST_WE_N;
         NAND_RE_N_OUT <= RST_RE_N;
         NAND_WP_N_OUT <= RST_WP_N;
         NAND_IO_OUT <= 16'h0000;
         NAND_IO_OE_OUT <= 1'b0;
         ack_reg <= 1'b0;
      end else if (CLK_EN_IN) begin
         NAND_WP_N_OUT <= WRITE_ALLOW_IN;
         ack_reg <= accept;
         if (accept && REQ_KIND_IN != NBHC_KIND_WAIT) begin
            NAND_CE_N_OUT <= 1'b0;
            NAND_CLE_OUT <= (REQ_KIND_IN == NBHC_KIND_CMD);
            NAND_ALE_OUT <= (REQ_KIND_IN == NBHC_KIND_ADDR);
            NAND_IO_OUT <= drive_val;
            NAND_IO_OE_OUT <= (REQ_KIND_IN != NBHC_KIND_DOUT);
         end else if (state_reg == ST_SETUP && cnt_reg <= 4'h1 &&
                      kind_reg != NBHC_KIND_WAIT) begin
            if (kind_reg == NBHC_KIND_DOUT) begin
               NAND_RE_N_OUT <= 1'b0;
            end else begin
               NAND_WE_N_OUT <= 1'b0;
            end
         end else if (state_reg == ST_LOW && cnt_reg <= 4'h1) begin
            NAND_WE_N_OUT <= 1'b1;
            NAND_RE_N_OUT <= 1'b1;
         end else if (state_reg == ST_HOLD && cnt_reg <= 4'h1) begin
            NAND_CE_N_OUT <= 1'b1;
            NAND_CLE_OUT <= 1'b0;
            NAND_ALE_OUT <= 1'b0;
            NAND_IO_OE_OUT <= 1'b0;
         end
      end
   end

   assign REQ_ACK_OUT = ack_reg;

   // Address cycle count and read mode tracking
   always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         addr_idx_reg <= 3'h0;
         rdmode_reg <= NBHC_RD_ARRAY;
      end else if (CLK_EN_IN && accept) begin
         if (REQ_KIND_IN == NBHC_KIND_CMD) begin
            addr_idx_reg <= 3'h0;
            if (REQ_DATA_IN[7:0] == CMD_STATUS) begin
               rdmode_reg <= NBHC_RD_STATUS;
            end else if (REQ_DATA_IN[7:0] == CMD_EDC_STATUS) begin
               rdmode_reg <= NBHC_RD_EDC;
            end else begin
               rdmode_reg <= NBHC_RD_ARRAY;
            end
         end else if (REQ_KIND_IN == NBHC_KIND_ADDR) begin
            addr_idx_reg <= (addr_idx_reg == ADDR_CYCLES - 3'h1) ?
               3'h0 : addr_idx_reg + 3'h1;
         end
      end
   end

   // Read capture at the end of the read strobe low phase
   assign push = (state_reg == ST_LOW) && (cnt_reg <= 4'h1) &&
      (kind_reg == NBHC_KIND_DOUT);

   always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         STAT_READY_OUT <= 1'b0;
         STAT_FAIL_OUT <= 1'b0;
      end else if (CLK_EN_IN && push && rdmode_reg == NBHC_RD_STATUS) begin
         STAT_READY_OUT <= io_sync_reg[STAT_BIT_READY];
         STAT_FAIL_OUT <= io_sync_reg[STAT_BIT_FAIL];
      end
   end

   nbhc_buf2 #(.WIDTH(IO_WIDTH)) u_rdbuf (
      .clk_in(SYS_CLK_IN),
      .rst_in(SYS_RST_IN),
      .en_in(CLK_EN_IN),
      .in_valid_in(push && CLK_EN_IN),
      .in_ready_out(buf_ready),
      .in_data_in(io_sync_reg),
      .out_valid_out(RD_VALID_OUT),
      .out_ready_in(RD_READY_IN),
      .out_data_out(RD_DATA_OUT)
   );

   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   we_rise_sel_a: assert property ($rose(NAND_WE_N_OUT) |->
      !NAND_CE_N_OUT && NAND_IO_OE_OUT && $stable(NAND_IO_OUT))
      else $error("write strobe rose without select or stable lanes");
   rd_no_drive_a: assert property (!NAND_RE_N_OUT |-> !NAND_IO_OE_OUT)
      else $error("lanes driven during read strobe");
   latch_excl_a: assert property (!(NAND_CLE_OUT && NAND_ALE_OUT))
      else $error("both latch strobes high");
   cmd_low_lanes_a: assert property (NAND_CLE_OUT |->
      NAND_IO_OUT[15:8] == 8'h00)
      else $error("command on upper lanes");
   addr_last_mask_a: assert property (accept &&
      REQ_KIND_IN == NBHC_KIND_ADDR && addr_idx_reg == ADDR_IDX_LAST
      |=> NAND_IO_OUT[7:2] == 6'h00)
      else $error("reserved lanes of last address cycle set");
   busy_cmd_a: assert property (accept && BUSY_OUT &&
      REQ_KIND_IN == NBHC_KIND_CMD |->
      REQ_DATA_IN[7:0] == CMD_RESET || REQ_DATA_IN[7:0] == CMD_STATUS)
      else $error("illegal command issued while busy");
   re_pulse_a: assert property ($fell(NAND_RE_N_OUT) && CLK_EN_IN
      |=> !NAND_RE_N_OUT)
      else $error("read strobe low too short");
   push_on_rise_a: assert property (push && CLK_EN_IN |=>
      NAND_RE_N_OUT && RD_VALID_OUT)
      else $error("read word not captured at strobe end");
   wp_follow_a: assert property (CLK_EN_IN |=>
      NAND_WP_N_OUT == $past(WRITE_ALLOW_IN))
      else $error("write protect not following permit");

endmodule : nbhc_host

// ---- bench/nbhc_dev_model.sv ----
/*
 * Behavioural model of the strobed flash device at the far side of
 * the host controller: command/address/data decode, a 16-word page,
 * status and error-detect words, open-drain ready/busy.
 * Assumes the bench resolves the lanes from the host enable only and pulls
 * the ready/busy line up.
 */
`timescale 1ns/100ps
module nbhc_dev_model #(
   parameter logic [15:0] ERR_DET_VAL = 16'h0010, // Arbitrary
   parameter logic [15:0] ID_VAL = 16'h005c // Arbitrary
) (
   input wire logic ce_n_in,            // Chip select
   input wire logic cle_in,             // Command latch
   input wire logic ale_in,             // Address latch
   input wire logic we_n_in,            // Write strobe
   input wire logic read_strobe_n_in,   // Read strobe
   input wire logic wp_n_in,            // Write protect
   input wire logic [15:0] io_in,       // Lane level
   output logic [15:0] io_out,          // Lane drive value
   output logic io_oe_out,              // Lane drive enable
   output logic rb_oe_out               // Pulls ready/busy low
);
   logic [15:0] mem [16];
   logic [15:0] pbuf [16];
   logic [15:0] addr_log [5];
   logic [15:0] cmd_raw;
   logic [7:0] last_cmd;
   logic [3:0] col;
   logic [1:0] mode;
   logic busy;
   int acnt;
   int bz_ns;

   initial begin
      busy = 1'b0;
      io_out = 16'h0000;
      mode = 2'h0;
      acnt = 0;
      col = 4'h0;
      last_cmd = 8'h00;
      cmd_raw = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'h0000;
         pbuf[i] = 16'h0000;
      end
   end

   task automatic start(input int ns);
      begin
         bz_ns = ns;
         busy = 1'b1;
      end
   endtask : start

   always @(posedge busy) begin
      #(bz_ns);
      busy = 1'b0;
   end

   always @(posedge we_n_in) begin
      if (!ce_n_in && read_strobe_n_in) begin
         if (cle_in && !ale_in) begin
            cmd_raw = io_in;
            if (!busy || io_in[7:0] == 8'hff || io_in[7:0] == 8'h70) begin
               last_cmd = io_in[7:0];
               acnt = 0;
               case (io_in[7:0])
                  8'h70: mode = 2'h1;
                  8'h7b: mode = 2'h2;
                  8'h90: mode = 2'h3;
                  8'h00, 8'h05, 8'he0, 8'h3f: mode = 2'h0;
                  8'h30, 8'h31: begin
                     mode = 2'h0;
                     start(500);
                  end
                  8'h11: start(200);
                  8'h10: if (wp_n_in) begin
                     for (int i = 0; i < 16; i++) mem[i] = pbuf[i];
                     start(2000);
                  end
                  8'hd0: if (wp_n_in) begin
                     for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
                     start(3000);
                  end
                  8'hff: start(200);
                  default: ;
               endcase
            end
         end else if (ale_in && !cle_in) begin
            if (acnt < 5) addr_log[acnt] = io_in;
            if (acnt == 0) col = io_in[3:0];
            acnt++;
         end else if (!cle_in && !ale_in && wp_n_in) begin
            pbuf[col] = io_in;
            col++;
         end
      end
   end

   always @(negedge read_strobe_n_in) begin
      if (!ce_n_in && !cle_in && !ale_in && we_n_in) begin
         case (mode)
            2'h1: io_out = {9'h000, !busy, 6'h00};
            2'h2: io_out = ERR_DET_VAL;
            2'h3: io_out = ID_VAL;
            default: begin
               io_out = mem[col];
               col++;
            end
         endcase
      end
   end

   // Released lanes flip on read strobe rise and flip back on chip select rise
   always @(posedge read_strobe_n_in or posedge ce_n_in) begin
      io_out = ~io_out;
   end
   assign io_oe_out = !ce_n_in && !read_strobe_n_in;
   assign rb_oe_out = busy;
endmodule : nbhc_dev_model

// ---- bench/nbhc_host_tb_top.sv ----
/*
 * Self-checking bench of the flash host controller against the
 * behavioural device model.
 * Assumes the 100 MHz clock and an open-drain ready/busy pull-up.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin \
   mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module nbhc_host_tb_top;
   import nbhc_pkg::*;
   localparam logic [15:0] DET_WORD = 16'h0010;
   logic clk, rst, wide, wr_allow, req_valid, rd_ready;
   nbhc_kind_type req_kind;
   logic [15:0] req_data, rd_data, h_io, d_io, io, w;
   logic req_ready, req_ack, rd_valid, stat_ready, stat_fail, busy;
   logic ce_n, cle, ale, we_n, read_strobe_n, wp_n, h_oe, d_oe, rb_oe;
   int mismatches, checks_done, acks;
   wire rb;

   assign io = h_oe ? h_io : d_io;
   assign rb = rb_oe ? 1'b0 : 1'b1;

   nbhc_host dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(1'b1),
      .WIDE_BUS_IN(wide), .WRITE_ALLOW_IN(wr_allow),
      .REQ_VALID_IN(req_valid), .REQ_KIND_IN(req_kind),
      .REQ_DATA_IN(req_data), .REQ_READY_OUT(req_ready),
      .REQ_ACK_OUT(req_ack), .RD_DATA_OUT(rd_data),
      .RD_VALID_OUT(rd_valid), .RD_READY_IN(rd_ready),
      .STAT_READY_OUT(stat_ready), .STAT_FAIL_OUT(stat_fail),
      .BUSY_OUT(busy), .NAND_CE_N_OUT(ce_n), .NAND_CLE_OUT(cle),
      .NAND_ALE_OUT(ale), .NAND_WE_N_OUT(we_n),
      .NAND_RE_N_OUT(read_strobe_n), .NAND_WP_N_OUT(wp_n),
      .NAND_IO_OUT(h_io), .NAND_IO_OE_OUT(h_oe), .NAND_IO_IN(io),
      .NAND_RB_IN(rb));

   nbhc_dev_model #(.ERR_DET_VAL(DET_WORD)) dev (.ce_n_in(ce_n),
      .cle_in(cle), .ale_in(ale), .we_n_in(we_n),
      .read_strobe_n_in(read_strobe_n), .wp_n_in(wp_n), .io_in(io),
      .io_out(d_io), .io_oe_out(d_oe), .rb_oe_out(rb_oe));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic conclude;
      begin
         $display("checks %0d mismatches %0d", checks_done, mismatches);
         if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
         end else begin
            $display("DONE - FAIL");
         end
         $finish;
      end
   endtask : conclude

   task automatic req_wait;
      int n;
      begin
         n = 0;
         while (req_ack !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
         end
         req_valid = 1'b0;
         while (req_ready !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
         end
         if (n >= 3000) begin
            mismatches++;
            $display("[ERR] handshake exp done got stuck");
         end
      end
   endtask : req_wait

   task automatic req(input nbhc_kind_type k, input logic [15:0] d);
      begin
         req_kind = k;
         req_data = d;
         req_valid = 1'b1;
         req_wait();
      end
   endtask : req

   // Holds a request for 15 cycles and counts acknowledges
   task automatic refuse_probe(input nbhc_kind_type k, output int a);
      begin
         a = 0;
         req_kind = k;
         req_valid = 1'b1;
         repeat (15) begin
            @(negedge clk);
            if (req_ack === 1'b1) a++;
         end
      end
   endtask : refuse_probe

   task automatic pop(output logic [15:0] v);
      int n;
      begin
         n = 0;
         while (rd_valid !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
         end
         v = rd_data;
         rd_ready = 1'b1;
         @(negedge clk);
         rd_ready = 1'b0;
         @(negedge clk);
      end
   endtask : pop

   task automatic addr5(input logic [15:0] a0, input logic [15:0] r);
      begin
         req(NBHC_KIND_ADDR, a0);
         repeat (4) req(NBHC_KIND_ADDR, r);
      end
   endtask : addr5

   task automatic open_page(input logic [3:0] c);
      begin
         req(NBHC_KIND_CMD, 16'h0000);
         addr5({12'h000, c}, 16'h0000);
         req(NBHC_KIND_CMD, 16'h0030);
         req(NBHC_KIND_WAIT, 16'h0000);
      end
   endtask : open_page

   task automatic t_addr_lanes;
      logic [15:0] e [5];
      begin
         for (int m = 0; m < 2; m++) begin
            wide = m[0];
            e = '{16'h00ff, m[0] ? 16'h0007 : 16'h000f, 16'h00ff,
               16'h00ff, 16'h0003};
            req(NBHC_KIND_CMD, 16'hab80);
            `CHK("cmd lanes", 16'h0080, dev.cmd_raw);
            addr5(16'hffff, 16'hffff);
            for (int i = 0; i < 5; i++)
               `CHK("addr lanes", e[i], dev.addr_log[i]);
         end
         req(NBHC_KIND_CMD, 16'h00ff);
         req(NBHC_KIND_WAIT, 16'h0000);
         $display("t_addr_lanes done");
      end
   endtask : t_addr_lanes

   task automatic t_prog_read;
      begin
         wr_allow = 1'b1;
         req(NBHC_KIND_CMD, 16'h0080);
         addr5(16'h0000, 16'h0000);
         req(NBHC_KIND_DIN, 16'ha5a5);
         req(NBHC_KIND_DIN, 16'h5a5a);
         req(NBHC_KIND_DIN, 16'h1234);
         req(NBHC_KIND_CMD, 16'h0010);
         `CHK("busy", 1'b1, busy);
         req(NBHC_KIND_WAIT, 16'h0000);
         req(NBHC_KIND_CMD, 16'h0070);
         req(NBHC_KIND_DOUT, 16'h0000);
         pop(w);
         `CHK("status", 16'h0040, w);
         `CHK("stat ready", 1'b1, stat_ready);
         `CHK("stat fail", 1'b0, stat_fail);
         open_page(4'h1);
         req(NBHC_KIND_DOUT, 16'h0000);
         pop(w);
         `CHK("word 1", 16'h5a5a, w);
         req(NBHC_KIND_DOUT, 16'h0000);
         pop(w);
         `CHK("word 2", 16'h1234, w);
         $display("t_prog_read done");
      end
   endtask : t_prog_read

   task automatic t_protect;
      begin
         wr_allow = 1'b0;
         repeat (2) @(negedge clk);
         `CHK("wp_n", 1'b0, wp_n);
         req(NBHC_KIND_CMD, 16'h0080);
         addr5(16'h0000, 16'h0000);
         req(NBHC_KIND_DIN, 16'h0000);
         req(NBHC_KIND_CMD, 16'h0010);
         req(NBHC_KIND_WAIT, 16'h0000);
         open_page(4'h0);
         req(NBHC_KIND_DOUT, 16'h0000);
         pop(w);
         `CHK("kept word", 16'ha5a5, w);
         $display("t_protect done");
      end
   endtask : t_protect

   task automatic t_busy;
      begin
         wr_allow = 1'b1;
         req(NBHC_KIND_CMD, 16'h0060);
         repeat (3) req(NBHC_KIND_ADDR, 16'h0000);
         req(NBHC_KIND_CMD, 16'h00d0);
         req(NBHC_KIND_CMD, 16'h0070);
         req(NBHC_KIND_DOUT, 16'h0000);
         pop(w);
         `CHK("busy status", 16'h0000, w);
         `CHK("stat ready", 1'b0, stat_ready);
         req_data = 16'h0090;
         refuse_probe(NBHC_KIND_CMD, acks);
         `CHK("busy refuse", 0, acks);
         `CHK("busy held", 1'b1, busy);
         req_wait();
         `CHK("late cmd", 8'h90, dev.last_cmd);
         $display("t_busy done");
      end
   endtask : t_busy

   task automatic t_err_detect;
      begin
         req(NBHC_KIND_CMD, 16'h007b);
         req(NBHC_KIND_DOUT, 16'h0000);
         req(NBHC_KIND_DOUT, 16'h0000);
         refuse_probe(NBHC_KIND_DOUT, acks);
         `CHK("full refuse", 0, acks);
         pop(w);
         `CHK("det word", DET_WORD, w);
         req_wait();
         repeat (2) begin
            pop(w);
            `CHK("det word", DET_WORD, w);
         end
         `CHK("drained", 1'b0, rd_valid);
         $display("t_err_detect done");
      end
   endtask : t_err_detect

   initial begin
      #200000;
      mismatches++;
      $display("[ERR] watchdog exp finish got timeout");
      conclude();
   end

   initial begin
      mismatches = 0;
      checks_done = 0;
      rst = 1'b1;
      wide = 1'b0;
      wr_allow = 1'b0;
      req_valid = 1'b0;
      req_kind = NBHC_KIND_CMD;
      req_data = 16'h0000;
      rd_ready = 1'b0;
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      `CHK("idle ce_n", 1'b1, ce_n);
      `CHK("idle oe", 1'b0, h_oe);
      t_addr_lanes();
      t_prog_read();
      t_protect();
      t_busy();
      t_err_detect();
      conclude();
   end
endmodule : nbhc_host_tb_top
